/* File: pmwm_pkg.sv */
// Package for the power mode and wake manager: mode codes, flag positions, voltage codes.
// Assumes nothing of its surroundings; every file names items as pmwm_pkg::name.
package pmwm_pkg;

	// Power-down mode select codes
	localparam logic [2:0] PDSEL_BASIC = 3'h0;
	localparam logic [2:0] PDSEL_LOW_LEAK = 3'h1;
	localparam logic [2:0] PDSEL_FAST_WAKE = 3'h2;
	localparam logic [2:0] PDSEL_ULTRA_LEAK = 3'h3;
	localparam logic [2:0] PDSEL_STANDBY = 3'h4;
	localparam logic [2:0] PDSEL_DEEP = 3'h6;

	// Bit positions of the control and flag fields
	localparam int DEEP_SLEEP_BIT = 2;
	localparam int PD_ENABLE_BIT = 7;
	localparam int BOD_FLAG_BIT = 4;
	localparam int PIN_GRP_LSB = 8;
	localparam int PIN_GRP_MSB = 11;
	localparam int RTC_WAKE_BIT = 5;
	localparam int CMP_STATUS_WAKE_BIT = 3;
	localparam int TIMER_WAKE_BIT = 1;
	localparam int TIMER_INT_BIT = 0;
	localparam int I2C_ACK_BIT = 1;
	localparam int I2C_WAKE_BIT = 0;
	localparam int CAN_WAKE_BIT = 0;
	localparam int OTG_EN_BIT = 5;
	localparam int CMP_FLAG0_BIT = 8;
	localparam int CMP_FLAG1_BIT = 9;
	localparam int WDT_WAKE_BIT = 5;
	localparam int UART_FLAGS = 5;

	// Number of standby wake pins
	localparam int STANDBY_PINS = 61;

	// Basic-group wake source indices
	localparam int SRC_EXT_IRQ = 0;
	localparam int SRC_GPIO = 1;
	localparam int SRC_USB_DEV = 2;
	localparam int SRC_USB_HOST = 3;
	localparam int SRC_CARD = 4;
	localparam int SRC_SERIAL = 5;
	localparam int SRC_RTC = 6;
	localparam int N_EXT_SRC = 7;

	// Core supply level codes (tenths of millivolt steps not needed; coded levels)
	localparam logic [2:0] VCORE_1V20 = 3'h0;
	localparam logic [2:0] VCORE_1V26 = 3'h1;
	localparam logic [2:0] VCORE_0V9 = 3'h2;
	localparam logic [2:0] VCORE_0V8 = 3'h3;
	localparam logic [2:0] VCORE_FLOAT = 3'h4;

	// Reset values
	localparam logic [3:0] PIN_GRP_RST = 4'h0;
	localparam logic [4:0] UART_FLAGS_RST = 5'h00;

	typedef enum logic [2:0] {
		ST_NORMAL = 3'b000,
		ST_IDLE = 3'b001,
		ST_PD = 3'b010,
		ST_STANDBY = 3'b011,
		ST_DEEP = 3'b100,
		ST_WAKE = 3'b101
	} pmwm_state_e;

endpackage : pmwm_pkg

/* File: pmwm_sync.sv */
// Two-stage synchroniser bank for asynchronous wake inputs.
// Assumes inputs come from pins or other clocks; outputs are in clk domain.
`timescale 1ns/1ps
`default_nettype none
module pmwm_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					meta_q[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta_q[i] <= d[i];
					q[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule : pmwm_sync
`default_nettype wire

/* File: pmwm_core.sv */
// Power mode and wake manager: mode entry on wait-for-interrupt, clock gating, core voltage, wake flags.
// Assumes the core pulses wfi_exec and drops it while halted; wake events arrive asynchronously.
// How it works
// - Reset gives normal mode, all clocks on.
// - Mode committed only on wait-for-interrupt.
// - Decode select bits into idle or power-down modes.
// - Idle gates only CPU; any interrupt wakes.
// - Power-down halts fast oscillators, PLL, bus, flash.
// - Low-speed peripheral clocks stay only if sourced.
// - Standby/deep: core off, only RTC low-speed.
// - Core voltage level per mode.
// - Enabled basic-group events return to normal.
// - Pin wakes in standby/deep; flags cleared entry.
// - Wake timer wakes standby/deep, sets flag.
// - RTC wakes standby/deep; flag cleared entry.
// - Five write-one-clear UART wake flags.
// - OTG id change wakes; enable needed.
// - Comparator wake flags, basic and standby.
`timescale 1ns/1ps
`default_nettype none
module pmwm_core (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Core and control
	input wire logic wfi_exec,
	input wire logic cpu_irq,
	input wire logic deep_sleep_select,
	input wire logic powerdown_enable,
	input wire logic [2:0] powerdown_mode_select,
	input wire logic turbo_en,
	input wire logic slow_xtal_sw_on,
	input wire logic slow_rc_sw_on,
	input wire logic timer_src_low,
	input wire logic wdt_src_slow_rc,
	input wire logic rtc_src_slow_xtal,
	input wire logic uart_src_slow_xtal,
	// Asynchronous wake events
	input wire logic [pmwm_pkg::N_EXT_SRC-1:0] ext_wake,
	input wire logic [pmwm_pkg::N_EXT_SRC-1:0] ext_wake_en,
	input wire logic bod_event,
	input wire logic timer_event,
	input wire logic wdt_event,
	input wire logic [pmwm_pkg::UART_FLAGS-1:0] uart_event,
	input wire logic i2c_match,
	input wire logic can_toggle,
	input wire logic otg_id_change,
	input wire logic [1:0] cmp_event,
	input wire logic cmp_status_change,
	input wire logic [pmwm_pkg::STANDBY_PINS-1:0] wake_pins,
	input wire logic [3:0] pin_group_map,
	input wire logic deep_wake_pin,
	input wire logic wake_timer_tmo,
	input wire logic rtc_event,
	// Software flag writes
	input wire logic brownout_clr,
	input wire logic [1:0] timer_clr,
	input wire logic wake_timer_clr,
	input wire logic [pmwm_pkg::UART_FLAGS-1:0] uart_clr,
	input wire logic i2c_ack_clr,
	input wire logic i2c_wake_clr,
	input wire logic can_wr_zero,
	input wire logic otg_wake_set,
	input wire logic [1:0] cmp_clr,
	input wire logic wdt_unlock,
	input wire logic wdt_clr,
	// Clock and supply controls
	output logic cpu_clk_en,
	output logic hs_osc_en,
	output logic pll_en,
	output logic bus_clk_en,
	output logic flash_en,
	output logic slow_xtal_en,
	output logic slow_rc_en,
	output logic timer_clk_en,
	output logic wdt_clk_en,
	output logic rtc_clk_en,
	output logic uart_clk_en,
	output logic other_clk_en,
	output logic core_power_en,
	output logic [2:0] vcore_level,
	output logic [2:0] mode_state,
	// Flags
	output logic brownout_int_flag,
	output logic [1:0] timer_flags,
	output logic wake_timer_flag,
	output logic rtc_wake_flag,
	output logic [3:0] pin_group_wake_flags,
	output logic dpd_pin_wake_flag,
	output logic analog_comparator_wake_flag,
	output logic [pmwm_pkg::UART_FLAGS-1:0] uart_wake_flags,
	output logic wake_ack_done,
	output logic i2c_wake_flag,
	output logic can_wake_status,
	output logic otg_wake_enable,
	output logic [1:0] comparator_wake_flags,
	output logic wdt_wake_flag
);
	localparam int NA = pmwm_pkg::N_EXT_SRC + pmwm_pkg::UART_FLAGS + 13;
	localparam int NP = pmwm_pkg::STANDBY_PINS;

	logic [NA-1:0] araw, asy;
	logic [NP-1:0] pins_s, pins_prev_q;
	logic [pmwm_pkg::N_EXT_SRC-1:0] ext_s;
	logic [pmwm_pkg::UART_FLAGS-1:0] uart_s;
	logic bod_s, tmr_s, wdt_s, i2c_s, can_s, otg_s, cmp_st_s, deep_pin_s, wkt_s, rtc_s;
	logic [1:0] cmp_s;
	logic deep_pin_prev_q, otg_prev_q, can_prev_q, cmp_prev_q;
	logic otg_edge, can_edge, cmp_edge, deep_pin_edge;
	pmwm_pkg::pmwm_state_e st_q, st_d;
	logic [2:0] pdsel_q;
	logic enter_pd, enter_sb, enter_dp, basic_wake, deep_wake, pin_edge;

	assign araw = {cpu_irq, bod_event, timer_event, wdt_event, i2c_match, can_toggle, otg_id_change,
		cmp_event, cmp_status_change, deep_wake_pin, wake_timer_tmo, rtc_event, uart_event, ext_wake};
	assign {bod_s, tmr_s, wdt_s, i2c_s, can_s, otg_s, cmp_s, cmp_st_s, deep_pin_s, wkt_s, rtc_s,
		uart_s, ext_s} = asy[NA-2:0];

	pmwm_sync #(.W(NA)) u_sync_ev (.clk(clk), .nrst(nrst), .d(araw), .q(asy));
	pmwm_sync #(.W(NP)) u_sync_pin (.clk(clk), .nrst(nrst), .d(wake_pins), .q(pins_s));

	// Edge detection on synchronised levels
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pins_prev_q <= '0;
			deep_pin_prev_q <= 1'b0;
			otg_prev_q <= 1'b0;
			can_prev_q <= 1'b0;
			cmp_prev_q <= 1'b0;
		end else begin
			pins_prev_q <= pins_s;
			deep_pin_prev_q <= deep_pin_s;
			otg_prev_q <= otg_s;
			can_prev_q <= can_s;
			cmp_prev_q <= cmp_st_s;
		end
	end
	assign otg_edge = otg_s ^ otg_prev_q;
	assign can_edge = can_s ^ can_prev_q;
	assign cmp_edge = cmp_st_s ^ cmp_prev_q;
	assign deep_pin_edge = deep_pin_s ^ deep_pin_prev_q;
	assign pin_edge = |(pins_s ^ pins_prev_q);

	// Entry strobes
	always_comb begin
		enter_pd = 1'b0;
		enter_sb = 1'b0;
		enter_dp = 1'b0;
		if (st_q == pmwm_pkg::ST_NORMAL && wfi_exec && deep_sleep_select && powerdown_enable) begin
			case (powerdown_mode_select)
				pmwm_pkg::PDSEL_BASIC, pmwm_pkg::PDSEL_LOW_LEAK,
				pmwm_pkg::PDSEL_FAST_WAKE, pmwm_pkg::PDSEL_ULTRA_LEAK: enter_pd = 1'b1;
				pmwm_pkg::PDSEL_STANDBY: enter_sb = 1'b1;
				pmwm_pkg::PDSEL_DEEP: enter_dp = 1'b1;
				default: enter_pd = 1'b0;
			endcase
		end
	end

	// Basic-group wake: any enabled source or pending flag
	assign basic_wake = |(ext_s & ext_wake_en) | brownout_int_flag | timer_flags[pmwm_pkg::TIMER_WAKE_BIT]
		| wdt_wake_flag | (|uart_wake_flags) | i2c_wake_flag | can_wake_status
		| (otg_edge & otg_wake_enable) | (|comparator_wake_flags);
	assign deep_wake = wake_timer_flag | rtc_wake_flag;

	// Mode state machine
	always_comb begin
		st_d = st_q;
		case (st_q)
			pmwm_pkg::ST_NORMAL: begin
				if (enter_pd)
					st_d = pmwm_pkg::ST_PD;
				else if (enter_sb)
					st_d = pmwm_pkg::ST_STANDBY;
				else if (enter_dp)
					st_d = pmwm_pkg::ST_DEEP;
				else if (wfi_exec && !deep_sleep_select && !powerdown_enable)
					st_d = pmwm_pkg::ST_IDLE;
			end
			pmwm_pkg::ST_IDLE: if (asy[NA-1]) st_d = pmwm_pkg::ST_NORMAL;
			pmwm_pkg::ST_PD: if (basic_wake) st_d = pmwm_pkg::ST_WAKE;
			pmwm_pkg::ST_STANDBY: if (deep_wake || |pin_group_wake_flags || analog_comparator_wake_flag) st_d = pmwm_pkg::ST_WAKE;
			pmwm_pkg::ST_DEEP: if (deep_wake || dpd_pin_wake_flag) st_d = pmwm_pkg::ST_WAKE;
			pmwm_pkg::ST_WAKE: st_d = pmwm_pkg::ST_NORMAL;
			default: st_d = pmwm_pkg::ST_NORMAL;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st_q <= pmwm_pkg::ST_NORMAL;
		else
			st_q <= st_d;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			pdsel_q <= pmwm_pkg::PDSEL_BASIC;
		else if (enter_pd)
			pdsel_q <= powerdown_mode_select;
	end

	// Clock gating and supply
	always_comb begin
		logic pd, off;
		pd = (st_q == pmwm_pkg::ST_PD);
		off = (st_q == pmwm_pkg::ST_STANDBY) || (st_q == pmwm_pkg::ST_DEEP);
		cpu_clk_en = (st_q == pmwm_pkg::ST_NORMAL);
		hs_osc_en = !(pd || off);
		pll_en = hs_osc_en;
		bus_clk_en = hs_osc_en;
		flash_en = hs_osc_en;
		other_clk_en = hs_osc_en;
		slow_xtal_en = (pd || off) ? slow_xtal_sw_on : 1'b1;
		slow_rc_en = (pd || off) ? slow_rc_sw_on : 1'b1;
		timer_clk_en = off ? 1'b0 : (pd ? (timer_src_low & (slow_xtal_sw_on | slow_rc_sw_on)) : 1'b1);
		wdt_clk_en = off ? 1'b0 : (pd ? (wdt_src_slow_rc & slow_rc_sw_on) : 1'b1);
		rtc_clk_en = (pd || off) ? (rtc_src_slow_xtal & slow_xtal_sw_on) : 1'b1;
		uart_clk_en = off ? 1'b0 : (pd ? (uart_src_slow_xtal & slow_xtal_sw_on) : 1'b1);
		core_power_en = !off;
		mode_state = st_q;
		if (off)
			vcore_level = pmwm_pkg::VCORE_FLOAT;
		else if (pd && pdsel_q == pmwm_pkg::PDSEL_LOW_LEAK)
			vcore_level = pmwm_pkg::VCORE_0V9;
		else if (pd && pdsel_q == pmwm_pkg::PDSEL_ULTRA_LEAK)
			vcore_level = pmwm_pkg::VCORE_0V8;
		else if (turbo_en && !pd)
			vcore_level = pmwm_pkg::VCORE_1V26;
		else
			vcore_level = pmwm_pkg::VCORE_1V20;
	end

	// Write-one-clear flags; set wins over clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			brownout_int_flag <= 1'b0;
			timer_flags <= 2'h0;
			uart_wake_flags <= pmwm_pkg::UART_FLAGS_RST;
			comparator_wake_flags <= 2'h0;
			wdt_wake_flag <= 1'b0;
		end else begin
			brownout_int_flag <= bod_s | (brownout_int_flag & ~brownout_clr);
			timer_flags <= {2{tmr_s}} | (timer_flags & ~timer_clr);
			uart_wake_flags <= uart_s | (uart_wake_flags & ~uart_clr);
			comparator_wake_flags <= cmp_s | (comparator_wake_flags & ~cmp_clr);
			wdt_wake_flag <= wdt_s | (wdt_wake_flag & ~(wdt_clr & wdt_unlock));
		end
	end

	// I2C ack ordering, CAN write-zero clear, OTG enable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_ack_done <= 1'b0;
			i2c_wake_flag <= 1'b0;
			can_wake_status <= 1'b0;
			otg_wake_enable <= 1'b0;
		end else begin
			wake_ack_done <= i2c_s | (wake_ack_done & ~i2c_ack_clr);
			i2c_wake_flag <= i2c_s | (i2c_wake_flag & ~(i2c_wake_clr & ~wake_ack_done));
			can_wake_status <= (can_edge & st_q == pmwm_pkg::ST_PD) | (can_wake_status & ~can_wr_zero);
			if (otg_wake_set)
				otg_wake_enable <= 1'b1;
			else if (st_q == pmwm_pkg::ST_PD && otg_edge)
				otg_wake_enable <= 1'b0;
		end
	end

	// Standby and deep flags, cleared at entry; the wake timer flag is cleared only by wake_timer_clr
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_group_wake_flags <= pmwm_pkg::PIN_GRP_RST;
			dpd_pin_wake_flag <= 1'b0;
			rtc_wake_flag <= 1'b0;
			analog_comparator_wake_flag <= 1'b0;
			wake_timer_flag <= 1'b0;
		end else begin
			if (enter_sb)
				pin_group_wake_flags <= pmwm_pkg::PIN_GRP_RST;
			else if (st_q == pmwm_pkg::ST_STANDBY && pin_edge)
				pin_group_wake_flags <= pin_group_wake_flags | pin_group_map;
			if (enter_dp)
				dpd_pin_wake_flag <= 1'b0;
			else if (st_q == pmwm_pkg::ST_DEEP && deep_pin_edge)
				dpd_pin_wake_flag <= 1'b1;
			if ((enter_sb || enter_dp) && !rtc_s)
				rtc_wake_flag <= 1'b0;
			else if (rtc_s && (st_q == pmwm_pkg::ST_STANDBY || st_q == pmwm_pkg::ST_DEEP))
				rtc_wake_flag <= 1'b1;
			if (enter_sb)
				analog_comparator_wake_flag <= 1'b0;
			else if (st_q == pmwm_pkg::ST_STANDBY && cmp_edge)
				analog_comparator_wake_flag <= 1'b1;
			if (wkt_s && (st_q == pmwm_pkg::ST_STANDBY || st_q == pmwm_pkg::ST_DEEP))
				wake_timer_flag <= 1'b1;
			else if (wake_timer_clr)
				wake_timer_flag <= 1'b0;
		end
	end

	// Assertions
	a_reset_normal: assert property (@(posedge clk) $rose(nrst) |-> st_q == pmwm_pkg::ST_NORMAL)
		else $error("not normal after reset");
	a_wfi_commit: assert property (@(posedge clk) disable iff (!nrst)
		(st_q == pmwm_pkg::ST_NORMAL && !wfi_exec) |=> st_q == pmwm_pkg::ST_NORMAL)
		else $error("mode left without wfi");
	a_idle_cpu_gate: assert property (@(posedge clk) disable iff (!nrst)
		st_q == pmwm_pkg::ST_IDLE |-> !cpu_clk_en && hs_osc_en && bus_clk_en)
		else $error("idle gating wrong");
	a_pd_halts: assert property (@(posedge clk) disable iff (!nrst)
		st_q == pmwm_pkg::ST_PD |-> !hs_osc_en && !pll_en && !flash_en && !other_clk_en)
		else $error("power-down clocks running");
	a_uart_lowclk: assert property (@(posedge clk) disable iff (!nrst)
		st_q == pmwm_pkg::ST_PD |-> uart_clk_en == (uart_src_slow_xtal && slow_xtal_sw_on))
		else $error("uart clock in power-down");
	a_standby_off: assert property (@(posedge clk) disable iff (!nrst)
		st_q == pmwm_pkg::ST_STANDBY |-> !core_power_en && !timer_clk_en && vcore_level == pmwm_pkg::VCORE_FLOAT)
		else $error("standby power wrong");
	sequence s_enter_sb;
		st_q == pmwm_pkg::ST_NORMAL ##1 st_q == pmwm_pkg::ST_STANDBY;
	endsequence
	a_pin_clear: assert property (@(posedge clk) disable iff (!nrst)
		s_enter_sb |-> pin_group_wake_flags == pmwm_pkg::PIN_GRP_RST && !analog_comparator_wake_flag)
		else $error("flags not cleared at standby entry");
	a_wake_exit: assert property (@(posedge clk) disable iff (!nrst)
		st_q == pmwm_pkg::ST_WAKE |=> st_q == pmwm_pkg::ST_NORMAL ##0 hs_osc_en)
		else $error("wake did not restore normal");
	a_timer_wake: assert property (@(posedge clk) disable iff (!nrst)
		(st_q == pmwm_pkg::ST_DEEP && wake_timer_flag) |=> st_q == pmwm_pkg::ST_WAKE)
		else $error("wake timer ignored");
	a_can_zero: assert property (@(posedge clk) disable iff (!nrst)
		(can_wake_status && !can_wr_zero) |=> can_wake_status)
		else $error("can status lost");
endmodule : pmwm_core
`default_nettype wire

/* File: pmwm_model.sv */
// Behavioural model of the processor core, the software and the wake sources around the manager.
// Assumes clk is the manager clock; the bench moves the event lines of this model directly.
`timescale 1ns/1ps
`default_nettype none
module pmwm_model (
	// Clock
	input wire logic clk,
	// Core side
	output logic wfi_exec, cpu_irq, deep_sleep_select, powerdown_enable, turbo_en,
	output logic [2:0] powerdown_mode_select,
	output logic slow_xtal_sw_on, slow_rc_sw_on, timer_src_low, wdt_src_slow_rc, rtc_src_slow_xtal,
	output logic uart_src_slow_xtal,
	// Wake sources, with the UART, timer and comparator flag writes
	output logic [pmwm_pkg::N_EXT_SRC-1:0] ext_wake, ext_wake_en,
	output logic bod_event, timer_event, wdt_event, i2c_match, can_toggle, otg_id_change,
	output logic cmp_status_change, deep_wake_pin, wake_timer_tmo, rtc_event,
	output logic [pmwm_pkg::UART_FLAGS-1:0] uart_event, uart_clr,
	output logic [1:0] cmp_event, timer_clr, cmp_clr,
	output logic [pmwm_pkg::STANDBY_PINS-1:0] wake_pins,
	output logic [3:0] pin_group_map,
	// Software flag writes
	output logic brownout_clr, wake_timer_clr, i2c_ack_clr, i2c_wake_clr, can_wr_zero,
	output logic otg_wake_set, wdt_unlock, wdt_clr
);
	initial begin
		{wfi_exec, cpu_irq, deep_sleep_select, powerdown_enable, turbo_en, powerdown_mode_select,
			slow_xtal_sw_on, slow_rc_sw_on, timer_src_low, wdt_src_slow_rc, rtc_src_slow_xtal,
			uart_src_slow_xtal, ext_wake, ext_wake_en, bod_event, timer_event, wdt_event, i2c_match,
			can_toggle, otg_id_change, cmp_status_change, deep_wake_pin, wake_timer_tmo, rtc_event,
			uart_event, uart_clr, cmp_event, timer_clr, cmp_clr, wake_pins,
			pin_group_map, brownout_clr, wake_timer_clr, i2c_ack_clr, i2c_wake_clr, can_wr_zero,
			otg_wake_set, wdt_unlock, wdt_clr} = '0;
	end

	// Selects first, then one wait-for-interrupt pulse
	task automatic enter(input logic ds, input logic pd, input logic [2:0] sel);
		@(posedge clk);
		deep_sleep_select <= ds;
		powerdown_enable <= pd;
		powerdown_mode_select <= sel;
		@(posedge clk);
		wfi_exec <= 1'b1;
		@(posedge clk);
		wfi_exec <= 1'b0;
		#1;
	endtask : enter

	// One-cycle software write to a flag
	task automatic sw_clear(input int k);
		@(posedge clk);
		case (k)
			0: brownout_clr <= 1'b1;
			1: timer_clr <= 2'h3;
			2: i2c_ack_clr <= 1'b1;
			3: i2c_wake_clr <= 1'b1;
			4: can_wr_zero <= 1'b1;
			5: otg_wake_set <= 1'b1;
			6: begin
				wdt_unlock <= 1'b1;
				wdt_clr <= 1'b1;
			end
			7: wdt_clr <= 1'b1;
			8: uart_clr <= 5'h1F;
			9: cmp_clr <= 2'h3;
			default: wake_timer_clr <= 1'b1;
		endcase
		@(posedge clk);
		{brownout_clr, timer_clr, i2c_ack_clr, i2c_wake_clr, can_wr_zero, otg_wake_set, wdt_unlock, wdt_clr,
			uart_clr, cmp_clr, wake_timer_clr} <= '0;
		#1;
	endtask : sw_clear
endmodule : pmwm_model
`default_nettype wire

/* File: pmwm_core_tb.sv */
// Self-checking bench for the power mode and wake manager: mode entry, clock gating, supply and wake flags.
// Assumes pmwm_model drives every manager input; clock and reset are made here.
`timescale 1ns/1ps
`default_nettype none
module pmwm_core_tb;
	logic clk, nrst;
	logic wfi_exec, cpu_irq, deep_sleep_select, powerdown_enable, turbo_en, slow_xtal_sw_on, slow_rc_sw_on;
	logic timer_src_low, wdt_src_slow_rc, rtc_src_slow_xtal, uart_src_slow_xtal;
	logic bod_event, timer_event, wdt_event;
	logic i2c_match, can_toggle, otg_id_change, cmp_status_change, deep_wake_pin, wake_timer_tmo, rtc_event;
	logic brownout_clr, wake_timer_clr, i2c_ack_clr, i2c_wake_clr, can_wr_zero, otg_wake_set, wdt_unlock, wdt_clr;
	logic [2:0] powerdown_mode_select, vcore_level, mode_state;
	logic [pmwm_pkg::N_EXT_SRC-1:0] ext_wake, ext_wake_en;
	logic [pmwm_pkg::UART_FLAGS-1:0] uart_event, uart_clr, uart_wake_flags;
	logic [1:0] cmp_event, timer_clr, cmp_clr, timer_flags, comparator_wake_flags;
	logic [pmwm_pkg::STANDBY_PINS-1:0] wake_pins;
	logic [3:0] pin_group_map, pin_group_wake_flags;
	logic cpu_clk_en, hs_osc_en, pll_en, bus_clk_en, flash_en, slow_xtal_en, slow_rc_en, timer_clk_en;
	logic wdt_clk_en;
	logic rtc_clk_en, uart_clk_en, other_clk_en, core_power_en, brownout_int_flag, wake_timer_flag;
	logic rtc_wake_flag, dpd_pin_wake_flag, analog_comparator_wake_flag, wake_ack_done, i2c_wake_flag, can_wake_status;
	logic otg_wake_enable, wdt_wake_flag;
	logic [12:0] clks;
	logic [14:0] flags;
	int n_fail = 0;
	int checks_done = 0;
	logic [14:0] exp_f [8] = '{15'h4002, 15'h3002, 15'h0F82, 15'h0062, 15'h001A, 15'h0006, 15'h0003, 15'h0000};
	logic [2:0] vexp [4] = '{pmwm_pkg::VCORE_1V20, pmwm_pkg::VCORE_0V9, pmwm_pkg::VCORE_1V20, pmwm_pkg::VCORE_0V8};
	int clr_k [8] = '{0, 1, 8, 9, 3, 4, 6, 5};

	assign clks = {cpu_clk_en, hs_osc_en, pll_en, bus_clk_en, flash_en, slow_xtal_en, slow_rc_en, timer_clk_en,
		wdt_clk_en, rtc_clk_en, uart_clk_en, other_clk_en, core_power_en};
	assign flags = {brownout_int_flag, timer_flags, uart_wake_flags, comparator_wake_flags, wake_ack_done,
		i2c_wake_flag, can_wake_status, otg_wake_enable, wdt_wake_flag};

	pmwm_model u_m (.*);
	pmwm_core u_dut (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic close_out();
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for a mode, then compare it
	task automatic wait_mode(input logic [2:0] exp);
		int n;
		n = 0;
		while (mode_state !== exp && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(mode_state, exp);
	endtask : wait_mode

	// Enter basic power-down, raise one wake source, return to normal
	task automatic pd_flag(input int k);
		u_m.enter(1'b1, 1'b1, pmwm_pkg::PDSEL_BASIC);
		chk(mode_state, pmwm_pkg::ST_PD);
		@(posedge clk);
		case (k)
			0: u_m.bod_event <= 1'b1;
			1: u_m.timer_event <= 1'b1;
			2: u_m.uart_event <= 5'h1F;
			3: u_m.cmp_event <= 2'h3;
			4: u_m.i2c_match <= 1'b1;
			5: u_m.can_toggle <= ~u_m.can_toggle;
			6: u_m.wdt_event <= 1'b1;
			default: u_m.otg_id_change <= ~u_m.otg_id_change;
		endcase
		wait_mode(pmwm_pkg::ST_NORMAL);
		@(posedge clk);
		{u_m.bod_event, u_m.timer_event, u_m.uart_event, u_m.cmp_event, u_m.i2c_match, u_m.wdt_event} <= '0;
		@(posedge clk);
		#1;
	endtask : pd_flag

	initial begin
		#500us;
		n_fail++;
		close_out();
	end

	initial begin
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(mode_state, pmwm_pkg::ST_NORMAL);
		chk(clks, 13'h1FFF);
		chk(vcore_level, pmwm_pkg::VCORE_1V20);
		chk(flags, 15'h0000);
		nrst <= 1'b1;
		@(posedge clk);
		{u_m.timer_src_low, u_m.wdt_src_slow_rc, u_m.rtc_src_slow_xtal, u_m.uart_src_slow_xtal,
			u_m.turbo_en} <= 5'h1F;
		u_m.ext_wake_en <= 7'h3F;
		u_m.pin_group_map <= 4'h2;
		@(posedge clk);
		#1;
		chk(vcore_level, pmwm_pkg::VCORE_1V26);
		@(posedge clk);
		u_m.turbo_en <= 1'b0;
		u_m.enter(1'b1, 1'b0, pmwm_pkg::PDSEL_BASIC);
		chk(mode_state, pmwm_pkg::ST_NORMAL);
		u_m.enter(1'b1, 1'b1, 3'h5);
		chk(mode_state, pmwm_pkg::ST_NORMAL);
		u_m.enter(1'b0, 1'b0, pmwm_pkg::PDSEL_BASIC);
		chk(mode_state, pmwm_pkg::ST_IDLE);
		chk(clks, 13'h0FFF);
		@(posedge clk);
		u_m.cpu_irq <= 1'b1;
		wait_mode(pmwm_pkg::ST_NORMAL);
		@(posedge clk);
		u_m.cpu_irq <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{u_m.slow_xtal_sw_on, u_m.slow_rc_sw_on} <= {2{i[0] == 1'b0}};
			u_m.enter(1'b1, 1'b1, 3'(i));
			chk(mode_state, pmwm_pkg::ST_PD);
			chk(clks, i[0] ? 13'h0001 : 13'h00FD);
			chk(vcore_level, vexp[i]);
			if (i == 0) begin
				u_m.ext_wake[6] <= 1'b1;
				repeat (8) @(posedge clk);
				#1;
				chk(mode_state, pmwm_pkg::ST_PD);
			end
			@(posedge clk);
			u_m.ext_wake <= 7'(1 << i);
			wait_mode(pmwm_pkg::ST_NORMAL);
			chk(clks | 13'h00C0, 13'h1FFF);
			@(posedge clk);
			u_m.ext_wake <= '0;
		end
		{u_m.slow_xtal_sw_on, u_m.slow_rc_sw_on} <= 2'h3;
		u_m.sw_clear(5);
		chk(flags, 15'h0002);
		for (int k = 0; k < 8; k++) begin
			pd_flag(k);
			chk(flags, exp_f[k]);
			if (k == 0) begin
				u_m.enter(1'b1, 1'b1, pmwm_pkg::PDSEL_BASIC);
				chk(mode_state, pmwm_pkg::ST_PD);
				wait_mode(pmwm_pkg::ST_NORMAL);
			end
			if (k == 4) begin
				u_m.sw_clear(3);
				chk(flags, 15'h001A);
				u_m.sw_clear(2);
			end
			if (k == 6) begin
				u_m.sw_clear(7);
				chk(flags, 15'h0003);
			end
			u_m.sw_clear(clr_k[k]);
			chk(flags, 15'h0002);
		end
		u_m.enter(1'b1, 1'b1, pmwm_pkg::PDSEL_STANDBY);
		chk(mode_state, pmwm_pkg::ST_STANDBY);
		chk(clks, 13'h00C8);
		chk(vcore_level, pmwm_pkg::VCORE_FLOAT);
		u_m.wake_pins[5] <= 1'b1;
		wait_mode(pmwm_pkg::ST_NORMAL);
		chk(pin_group_wake_flags, 4'h2);
		u_m.enter(1'b1, 1'b1, pmwm_pkg::PDSEL_STANDBY);
		chk(pin_group_wake_flags, 4'h0);
		u_m.wake_timer_tmo <= 1'b1;
		wait_mode(pmwm_pkg::ST_NORMAL);
		u_m.wake_timer_tmo <= 1'b0;
		chk(wake_timer_flag, 1'b1);
		u_m.sw_clear(10);
		chk(wake_timer_flag, 1'b0);
		u_m.enter(1'b1, 1'b1, pmwm_pkg::PDSEL_STANDBY);
		u_m.cmp_status_change <= 1'b1;
		wait_mode(pmwm_pkg::ST_NORMAL);
		chk(analog_comparator_wake_flag, 1'b1);
		u_m.enter(1'b1, 1'b1, pmwm_pkg::PDSEL_STANDBY);
		chk(analog_comparator_wake_flag, 1'b0);
		u_m.rtc_event <= 1'b1;
		wait_mode(pmwm_pkg::ST_NORMAL);
		u_m.rtc_event <= 1'b0;
		chk(rtc_wake_flag, 1'b1);
		u_m.enter(1'b1, 1'b1, pmwm_pkg::PDSEL_DEEP);
		chk(mode_state, pmwm_pkg::ST_DEEP);
		chk(clks, 13'h00C8);
		chk(rtc_wake_flag, 1'b0);
		u_m.wake_pins[7] <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		chk(mode_state, pmwm_pkg::ST_DEEP);
		u_m.deep_wake_pin <= 1'b1;
		wait_mode(pmwm_pkg::ST_NORMAL);
		chk(dpd_pin_wake_flag, 1'b1);
		u_m.enter(1'b1, 1'b1, pmwm_pkg::PDSEL_DEEP);
		chk(mode_state, pmwm_pkg::ST_DEEP);
		chk(dpd_pin_wake_flag, 1'b0);
		@(posedge clk);
		u_m.wake_timer_tmo <= 1'b1;
		wait_mode(pmwm_pkg::ST_NORMAL);
		chk(wake_timer_flag, 1'b1);
		close_out();
	end
endmodule : pmwm_core_tb
`default_nettype wire
